// ==== fcs_pkg.sv ====
package fcs_pkg;

    // ***********************************************************************
    // Command bytes written on the data bus
    // ***********************************************************************
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR = 8'h50;
    localparam logic [7:0] CMD_IDENT = 8'h90;
    localparam int STATUS_READY_POS = 7;

    // ***********************************************************************
    // Timing, in ns and in 25 ns clock cycles
    // ***********************************************************************
    localparam int CLK_NS = 25;
    localparam int T_WP_NS = 50;
    localparam int T_WPH_NS = 20;
    localparam int T_ACC_NS = 70;
    localparam int T_RELOCK_NS = 100;
    localparam int T_RECOVER_NS = 450;
    localparam int T_RESET_LOW_NS = 60;
    localparam int SYNC_STAGES = 2;
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
    localparam int RELOCK_CYC = (T_RELOCK_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_LOW_CYC = (T_RESET_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 5;

    // ***********************************************************************
    // User operations and carriers
    // ***********************************************************************
    typedef enum logic [2:0] {
        OP_READ, OP_PROGRAM, OP_ERASE, OP_SUSPEND,
        OP_RESUME, OP_STATUS, OP_IDENT, OP_CLEAR
    } fcs_op_t;

    typedef struct packed {
        fcs_op_t op;
        logic boot;
        logic [18:0] addr;
        logic [15:0] data;
    } fcs_req_t;

    typedef struct packed {
        logic polled;
        logic [15:0] data;
    } fcs_rsp_t;

endpackage

// ==== fcs_sync.sv ====
`timescale 1ns/10ps
module fcs_sync #(
    parameter int W = 16
) (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic clk_en, // Freezes state when low
    input wire logic [W-1:0] d, // Asynchronous input
    output logic [W-1:0] q // Synchronised output
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (reset) begin
            meta <= '0;
            q <= '0;
        end else if (clk_en) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // fcs_sync

// ==== fcs_host.sv ====
`timescale 1ns/10ps
module fcs_host import fcs_pkg::*; #(
    parameter int ADDR_W = 19,
    parameter int DATA_W = 16
) (
    input wire logic clk, // 40 MHz clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic clk_en, // Freezes all state while low
    input wire logic req_valid, // Operation request
    input wire fcs_req_t req, // Operation, address, data, boot flag
    output logic req_ready, // Idle and able to take a request
    output logic rsp_valid, // One-cycle pulse: operation finished
    output fcs_rsp_t rsp, // Last read data and poll flag
    output logic flash_ce_n, // Chip enable
    output logic flash_we_n, // Write strobe
    output logic flash_oe_n, // Output enable
    output logic [ADDR_W-1:0] flash_addr, // Address pins
    output logic [DATA_W-1:0] flash_dq_out, // Data pins, driven value
    output logic flash_dq_oe, // Data pins driven when high
    input wire logic [DATA_W-1:0] flash_dq_in, // Data pins, sensed value
    output logic reset_powerdown_n, // Flash reset and power-down
    output logic boot_unlock // Boot-block write-protect release
);
    // ***********************************************************************
    // State
    // ***********************************************************************
    typedef enum logic [3:0] {
        S_PWRDN, S_RECOVER, S_IDLE, S_WR_SETUP, S_WR_PULSE, S_WR_END,
        S_GAP, S_RD, S_CHECK, S_RELOCK, S_DONE
    } fcs_state_t;

    fcs_state_t st, next_st;
    logic [CNT_W-1:0] cnt, next_cnt;
    fcs_op_t op;
    logic step;
    logic boot;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rd;
    logic [DATA_W-1:0] dq_sync;

    fcs_sync #(.W(DATA_W)) u_dq_sync (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .d(flash_dq_in),
        .q(dq_sync)
    );

    function automatic logic two_writes(input fcs_op_t o);
        return (o == OP_PROGRAM) || (o == OP_ERASE);
    endfunction

    function automatic logic polls(input fcs_op_t o);
        return (o == OP_PROGRAM) || (o == OP_ERASE) || (o == OP_SUSPEND);
    endfunction

    function automatic logic reads_back(input fcs_op_t o);
        return (o != OP_RESUME) && (o != OP_CLEAR);
    endfunction

    function automatic logic [7:0] cmd_byte(input fcs_op_t o);
        case (o)
            OP_PROGRAM: return CMD_PROGRAM;
            OP_ERASE: return CMD_ERASE;
            OP_SUSPEND: return CMD_SUSPEND;
            OP_RESUME: return CMD_CONFIRM;
            OP_STATUS: return CMD_STATUS;
            OP_IDENT: return CMD_IDENT;
            OP_CLEAR: return CMD_CLEAR;
            default: return CMD_READ_ARRAY;
        endcase
    endfunction

    function automatic logic in_cycle(input fcs_state_t s);
        return (s == S_WR_SETUP) || (s == S_WR_PULSE) || (s == S_RD);
    endfunction

    // ***********************************************************************
    // Sequencer
    // ***********************************************************************
    always_comb begin
        next_st = st;
        next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
        case (st)
            S_PWRDN: begin
                if (cnt == '0) begin
                    next_st = S_RECOVER;
                    next_cnt = CNT_W'(RECOVER_CYC - 1);
                end
            end
            S_RECOVER: begin
                if (cnt == '0) next_st = S_IDLE;
            end
            S_IDLE: begin
                if (req_valid) next_st = S_WR_SETUP;
            end
            S_WR_SETUP: begin
                next_st = S_WR_PULSE;
                next_cnt = CNT_W'(WP_CYC - 1);
            end
            S_WR_PULSE: begin
                if (cnt == '0) next_st = S_WR_END;
            end
            S_WR_END: begin
                next_st = S_GAP;
                next_cnt = CNT_W'(WPH_CYC - 1);
            end
            S_GAP: begin
                if (cnt == '0) begin
                    if (two_writes(op) && !step) begin
                        next_st = S_WR_SETUP;
                    end else if (reads_back(op)) begin
                        next_st = S_RD;
                        next_cnt = CNT_W'(RD_CYC - 1);
                    end else if (boot) begin
                        // Ops with no read still relock, so unlock never outlives its request
                        next_st = S_RELOCK;
                        next_cnt = CNT_W'(RELOCK_CYC - 1);
                    end else begin
                        next_st = S_DONE;
                    end
                end
            end
            S_RD: begin
                if (cnt == '0) next_st = S_CHECK;
            end
            S_CHECK: begin
                if (polls(op) && !rd[STATUS_READY_POS]) begin
                    next_st = S_RD;
                    next_cnt = CNT_W'(RD_CYC - 1);
                end else if (boot) begin
                    next_st = S_RELOCK;
                    next_cnt = CNT_W'(RELOCK_CYC - 1);
                end else begin
                    next_st = S_DONE;
                end
            end
            S_RELOCK: begin
                if (cnt == '0) next_st = S_DONE;
            end
            S_DONE: next_st = S_IDLE;
            default: next_st = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= S_PWRDN;
            cnt <= CNT_W'(RESET_LOW_CYC - 1);
        end else if (clk_en) begin
            st <= next_st;
            cnt <= next_cnt;
        end
    end

    // ***********************************************************************
    // Operation capture
    // ***********************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            op <= OP_READ;
            step <= 1'b0;
            wdata <= '0;
            flash_addr <= '0;
        end else if (clk_en) begin
            if (st == S_IDLE && req_valid) begin
                op <= req.op;
                step <= 1'b0;
                wdata <= DATA_W'(req.data);
                flash_addr <= ADDR_W'(req.addr);
            end else if (st == S_GAP && next_st == S_WR_SETUP) begin
                step <= 1'b1;
            end
        end
    end

    // Unlock stays up through polling and drops once the last read is checked, or after the writes for ops with no read
    always_ff @(posedge clk) begin
        if (reset) begin
            boot <= 1'b0;
            boot_unlock <= 1'b0;
        end else if (clk_en) begin
            if (st == S_IDLE && req_valid) begin
                boot <= req.boot;
                boot_unlock <= req.boot;
            end else if (next_st == S_RELOCK) begin
                boot_unlock <= 1'b0;
            end
        end
    end

    // ***********************************************************************
    // Pins, registered from the next state
    // ***********************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            flash_ce_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            flash_dq_out <= '0;
            reset_powerdown_n <= 1'b0;
        end else if (clk_en) begin
            flash_ce_n <= !in_cycle(next_st);
            flash_we_n <= (next_st != S_WR_PULSE);
            flash_oe_n <= (next_st != S_RD);
            // Data stays driven one cycle past the strobe rise
            flash_dq_oe <= (next_st == S_WR_SETUP) || (next_st == S_WR_PULSE)
                || (next_st == S_WR_END);
            if (next_st == S_WR_SETUP) begin
                flash_dq_out <= (st == S_GAP && op == OP_PROGRAM) ? wdata
                    : DATA_W'(cmd_byte(st == S_GAP ? OP_RESUME : req.op));
            end
            reset_powerdown_n <= (next_st != S_PWRDN);
        end
    end

    // ***********************************************************************
    // Read capture and answer
    // ***********************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            rd <= '0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else if (clk_en) begin
            if (st == S_RD && cnt == '0) rd <= dq_sync;
            req_ready <= (next_st == S_IDLE);
            rsp_valid <= (next_st == S_DONE);
            if (next_st == S_DONE) begin
                rsp.data <= 16'(rd);
                rsp.polled <= polls(op);
            end
        end
    end

    // ***********************************************************************
    // Assertions
    // ***********************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset || !clk_en);

    a_write_pulse_width: assert property ($fell(flash_we_n) |->
        !flash_we_n ##1 !flash_we_n ##1 flash_we_n)
        else $error("write pulse not two cycles");
    a_ce_covers_we: assert property (!flash_we_n |-> !flash_ce_n)
        else $error("write strobe low without chip enable");
    a_data_held: assert property ($rose(flash_we_n) && !$past(reset)
        |-> $past(flash_dq_oe) && flash_dq_oe)
        else $error("data not held across strobe rise");
    a_no_contention: assert property (!(flash_dq_oe && !flash_oe_n))
        else $error("bus driven while output enabled");
    a_cmd_program: assert property ($fell(flash_we_n) && op == OP_PROGRAM && !step
        |-> flash_dq_out[7:0] == CMD_PROGRAM)
        else $error("program setup byte wrong");
    a_program_data: assert property ($fell(flash_we_n) && op == OP_PROGRAM && step
        |-> flash_dq_out == wdata)
        else $error("program data write wrong");
    a_erase_confirm: assert property ($fell(flash_we_n) && op == OP_ERASE && step
        |-> flash_dq_out[7:0] == CMD_CONFIRM)
        else $error("erase confirm byte wrong");
    a_poll_done: assert property (rsp_valid && rsp.polled
        |-> rsp.data[STATUS_READY_POS])
        else $error("finished before ready bit set");
    a_unlock_drop: assert property ($fell(boot_unlock) |-> st == S_RELOCK)
        else $error("unlock dropped before completion");
    a_relock_wait: assert property ($fell(boot_unlock) |-> !rsp_valid [*4])
        else $error("done reported inside relock delay");

    c_program_done: cover property (rsp_valid && op == OP_PROGRAM);
    c_erase_done: cover property (rsp_valid && op == OP_ERASE);
    c_boot_relock: cover property ($fell(boot_unlock) ##[1:8] rsp_valid);
    c_ident_read: cover property (rsp_valid && op == OP_IDENT);
endmodule // fcs_host

// ==== fcs_flash_model.sv ====
`timescale 1ns/10ps
module fcs_flash_model import fcs_pkg::*; #(
    parameter logic [15:0] MAKER_ID = 16'h00a5, // Arbitrary value
    parameter logic [15:0] PART_ID = 16'h005a // Arbitrary value
) (
    input wire logic clk, // Bench clock, paces the busy phase and the power-down clear of state and busy
    input wire logic ce_n, // Chip enable
    input wire logic we_n, // Write strobe
    input wire logic oe_n, // Output enable
    input wire logic [18:0] addr, // Address pins
    input wire logic [15:0] din, // Data seen on the pins
    input wire logic reset_powerdown_n, // Reset and power-down
    input wire logic boot_unlock, // Boot-block protection release
    input wire logic [31:0] busy_cyc, // Length of the next program or erase
    output logic [15:0] q // Data driven by the device
);
    // ***********************************************************************
    // States: 0 array, 1 program setup, 2 program, 3 erase setup, 4 error,
    // 5 erase, 6 suspended to status, 7 suspended to array, 8 status, 9 id
    // ***********************************************************************
    logic [15:0] mem [256];
    logic [15:0] rd;
    logic [15:0] last = 16'h0000;
    int st = 0;
    int busy = 0;
    wire wr_on = !ce_n && !we_n;
    wire rd_on = !ce_n && !oe_n;
    wire prot = addr[18:15] == 4'h0 && !boot_unlock;

    initial foreach (mem[i]) mem[i] = 16'hffff;

    always @(negedge wr_on) begin
        if (!reset_powerdown_n) begin
        end else if (st == 1) begin
            if (!prot) mem[addr[7:0]] = mem[addr[7:0]] & din;
            busy = busy_cyc;
            st = 2;
        end else if (st == 3) begin
            st = din[7:0] == CMD_CONFIRM ? 5 : 4;
            if (st == 5) busy = busy_cyc;
            if (st == 5 && !prot) foreach (mem[i]) mem[i] = 16'hffff;
        end else if (busy > 0 && st == 5) begin
            if (din[7:0] == CMD_SUSPEND) st = 6;
        end else if (busy > 0 && st == 2) begin
        end else if (st == 6 || st == 7) begin
            case (din[7:0])
                CMD_CONFIRM: st = 5;
                CMD_STATUS: st = 6;
                8'h10, CMD_PROGRAM, CMD_IDENT: st = st;
                default: st = 7;
            endcase
        end else begin
            case (din[7:0])
                8'h10, CMD_PROGRAM: st = 1;
                CMD_ERASE: st = 3;
                CMD_STATUS: st = 8;
                CMD_IDENT: st = 9;
                default: st = 0;
            endcase
        end
    end

    // Busy time runs on the bench clock so that the test can pick it
    always @(posedge clk) begin
        if (!reset_powerdown_n) begin
            st = 0;
            busy = 0;
        end else if (busy > 0 && st < 6) busy = busy - 1;
    end

    always_comb begin
        if (st == 0 || st == 7) rd = mem[addr[7:0]];
        else if (st == 9) rd = addr[0] ? PART_ID : MAKER_ID;
        // A suspended erase reports ready although work remains
        else rd = {8'h00, busy == 0 || st == 6, 7'h00};
    end

    // Released pins show the inverse of the last word, never a kind value
    always @(rd or rd_on) if (rd_on) last = rd;
    assign q = rd_on ? rd : ~last;
endmodule // fcs_flash_model

// ==== flash_command_state_machine_tb.sv ====
`timescale 1ns/10ps
module flash_command_state_machine_tb import fcs_pkg::*;;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic req_valid = 1'b0;
    logic stall = 1'b0;
    fcs_req_t req = '0;
    fcs_rsp_t rsp;
    logic req_ready, rsp_valid, ce_n, we_n, oe_n, dq_oe, rp_n, unlock;
    logic [18:0] addr;
    logic [15:0] dq_out, fl_q, last = 16'h0000;
    logic [15:0] ref_mem [256];
    logic [31:0] seed = 32'd97706;
    logic [31:0] r;
    wire [15:0] dq = dq_oe ? dq_out : fl_q;
    int busy_cyc = 25;
    int error_cnt = 0;
    int n_tests = 0;

    always #12.5 clk = ~clk;

    fcs_host dut_u (.clk(clk), .reset(reset), .clk_en(clk_en), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .flash_ce_n(ce_n),
        .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_addr(addr), .flash_dq_out(dq_out),
        .flash_dq_oe(dq_oe), .flash_dq_in(dq), .reset_powerdown_n(rp_n), .boot_unlock(unlock));

    fcs_flash_model #(.MAKER_ID(16'h00a5), .PART_ID(16'h005a)) flash_u (.clk(clk),
        .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .din(dq),
        .reset_powerdown_n(rp_n), .boot_unlock(unlock), .busy_cyc(busy_cyc), .q(fl_q));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Random freezes stretch every pin phase without changing any result
    always @(negedge clk) clk_en <= !stall || (xs() & 32'h3) != 32'h0;

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ***********************************************************************
    // One request, reference outcome and comparison
    // ***********************************************************************
    task automatic run(input fcs_op_t op, input logic [18:0] a, input logic [15:0] d,
                       input logic b);
        logic [15:0] e;
        logic p;
        int n;
        p = op inside {OP_PROGRAM, OP_ERASE, OP_SUSPEND};
        case (op)
            OP_READ, OP_SUSPEND: e = ref_mem[a[7:0]];
            OP_PROGRAM: begin
                if (a[18:15] != 4'h0 || b) ref_mem[a[7:0]] &= d;
                e = 16'h0080;
            end
            OP_ERASE: begin
                if (a[18:15] != 4'h0 || b) foreach (ref_mem[i]) ref_mem[i] = 16'hffff;
                e = 16'h0080;
            end
            OP_STATUS: e = 16'h0080;
            OP_IDENT: e = a[0] ? 16'h005a : 16'h00a5;
            default: e = last;
        endcase
        last = e;
        n = 0;
        while (!req_ready && n < 400) begin
            @(negedge clk);
            n++;
        end
        req_valid = 1'b1;
        req = {op, b, a, d};
        do begin
            @(negedge clk);
            n++;
        end while (req_ready && n < 800);
        req_valid = 1'b0;
        while (!rsp_valid && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (!rsp_valid) error_cnt++;
        chk({rsp.polled, rsp.data}, {p, e});
    endtask

    initial begin
        foreach (ref_mem[i]) ref_mem[i] = 16'hffff;
        repeat (16) @(negedge clk);
        reset = 1'b0;
        run(OP_IDENT, 19'h40000, 16'h0000, 1'b0);
        run(OP_IDENT, 19'h40001, 16'h0000, 1'b0);
        run(OP_STATUS, 19'h40000, 16'h0000, 1'b0);
        run(OP_ERASE, 19'h40000, 16'h0000, 1'b0);
        run(OP_PROGRAM, 19'h40005, 16'h1234, 1'b0);
        run(OP_READ, 19'h40005, 16'h0000, 1'b0);
        busy_cyc = 0;
        run(OP_PROGRAM, 19'h40005, 16'hff00, 1'b0);
        run(OP_READ, 19'h40005, 16'h0000, 1'b0);
        run(OP_PROGRAM, 19'h00007, 16'h0f0f, 1'b0);
        run(OP_READ, 19'h00007, 16'h0000, 1'b0);
        run(OP_PROGRAM, 19'h00007, 16'h0f0f, 1'b1);
        run(OP_READ, 19'h00007, 16'h0000, 1'b0);
        run(OP_SUSPEND, 19'h40009, 16'h0000, 1'b0);
        run(OP_RESUME, 19'h40009, 16'h0000, 1'b0);
        run(OP_CLEAR, 19'h40009, 16'h0000, 1'b0);
        for (int i = 0; i < 40; i++) begin
            if (i == 20) begin
                reset = 1'b1;
                repeat (16) @(negedge clk);
                reset = 1'b0;
                run(OP_READ, 19'h40005, 16'h0000, 1'b0);
            end
            r = xs();
            busy_cyc = int'(r[7:2]);
            stall = r[8];
            req.op = fcs_op_t'(r[11:9]);
            if (req.op == OP_SUSPEND && !ref_mem[r[19:12]][7]) req.op = OP_READ;
            run(req.op, {r[0] ? 4'h0 : r[31:28], 7'h00, r[19:12]}, 16'(xs() >> 16), r[1]);
        end
        test_done();
    end

    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        test_done();
    end
endmodule // flash_command_state_machine_tb
